// >>> acs_device.sv
// amplifier end: reset, power-down, fault recovery, soft-mute ramp, headphone switch
// assumes link pins are synchronous to clk and the host keeps its own timing
//
// Notes on behaviour
// - source gives 32 to 64 bit clocks per frame
// - host holds reset low about 1 ms
// - valid drops 300 ns after reset, 725 us after power-down
// - running 10 ms after start command; host waits
// - reset ignored while powered down
// - power-down ignored while in reset
// - power-down held 800 ns; restart takes 120 ms
// - fault input held low at least 350 ns
// - speakers forced low within 350 ns of fault
// - hold speakers low programmable time, retry if clear
// - ramp time is step count times step size
// - step size 4, 8 or 16 frames by rate
// - host holds headphone select at least 350 ns
// - headphone switch ramps at configured volume rate
// - line-disable bit gates headphone output while hpActive is low
//
// Added by the designer: register access over AHB-Lite and the register offsets.
`timescale 1ns/10ps
`include "acs_defines.svh"
module acs_device import acs_pkg::*; #(
	parameter int DW = 16,
	parameter int CYC_PER_MS = 1000 * `ACS_CLK_MHZ,
	parameter int T_VALID_PD = `ACS_T_VALID_PD_US * `ACS_CLK_MHZ,
	parameter int T_CTL = `ACS_T_CTL_US * `ACS_CLK_MHZ,
	parameter int T_RUN = `ACS_T_RUN_MS * CYC_PER_MS,
	parameter int T_STARTUP = `ACS_T_STARTUP_MS * CYC_PER_MS
) (
	// clock, reset, enable
	input wire logic clk,
	input wire logic rst_n,
	input wire logic ce,
	// link to the host
	acs_link_if.device link,
	// power stage side
	input wire logic backend_fault_n,
	output logic powerStageValid,
	output logic speakerLow,
	// headphone path and volume
	output logic headphone_pwm_out,
	output logic hpActive,
	output logic [DW-1:0] volumeLevel
);
	// valid-drop delay after reset, a least time rounded up
	localparam int T_VALID_RST = (`ACS_T_VALID_RST_NS * `ACS_CLK_MHZ + 999) / 1000;

	acs_dev_state_t state; // sequencer state
	acs_dev_state_t next_state; // sequencer next state
	logic [31:0] tmrLoadVal; // delay for the state being entered
	logic tmrZero; // current delay has run out
	logic [DW-1:0] volCfg; // rate select in the low bits
	logic [DW-1:0] rampSteps; // steps of a full ramp
	logic [DW-1:0] hpCfg; // headphone configuration
	logic [DW-1:0] faultHold; // speaker-low hold time in ms
	logic ctlAck; // one-cycle acknowledge
	logic [DW-1:0] ctlRdata; // read data, held until next read
	logic frameQ; // frame clock one cycle ago
	logic [4:0] frameCnt; // frames within the current step
	logic [DW-1:0] readMux;
	logic [4:0] stepSize;
	logic [DW-1:0] volTarget;

	// state decode
	wire inReset = (state == ACS_ST_RESET) || (state == ACS_ST_RSTDLY);
	wire inPd = (state == ACS_ST_PDDLY) || (state == ACS_ST_PDOWN);
	wire ctlEnabled = !inReset && (state != ACS_ST_CTLWAIT) && (state != ACS_ST_PDOWN);
	wire ctlHit = link.ctlValid && ctlEnabled && !ctlAck;
	wire ctlWr = ctlHit && link.ctlWrite;
	wire startCmd = ctlWr && (link.ctlAddr == `ACS_REG_SYS)
		&& link.ctlWdata[`ACS_SYS_START];
	wire tmrLoad = (next_state != state);
	wire [31:0] faultCycles = 32'(faultHold) * 32'(CYC_PER_MS);

	// one timer serves every sequencer delay, counting on clk only while ce is high
	acs_timer #(.W(32)) seqTimer (
		.clk(clk),
		.rst_n(rst_n),
		.ce(ce),
		.load(tmrLoad),
		.loadVal(tmrLoadVal),
		.zero(tmrZero)
	);

	// sequencer transitions; pins checked last override
	always_comb begin
		next_state = state;
		case (state)
			ACS_ST_RSTDLY: begin
				if (tmrZero) next_state = ACS_ST_RESET;
			end
			ACS_ST_RESET: begin
				if (link.resetPin_n) next_state = ACS_ST_CTLWAIT;
			end
			ACS_ST_CTLWAIT: begin
				if (tmrZero) next_state = ACS_ST_IDLE;
			end
			ACS_ST_IDLE: begin
				if (startCmd) next_state = ACS_ST_STARTUP;
			end
			ACS_ST_STARTUP: begin
				if (tmrZero) next_state = ACS_ST_RUN;
			end
			ACS_ST_RUN: begin
				// one low sample suffices
				if (!backend_fault_n) next_state = ACS_ST_FAULT;
			end
			ACS_ST_FAULT: begin
				if (tmrZero && backend_fault_n) next_state = ACS_ST_RUN;
			end
			ACS_ST_PDDLY: begin
				if (tmrZero) next_state = ACS_ST_PDOWN;
			end
			ACS_ST_PDOWN: begin
				if (link.power_down_n) next_state = ACS_ST_PDSTART;
			end
			ACS_ST_PDSTART: begin
				if (tmrZero) next_state = ACS_ST_RUN;
			end
			default: begin
				next_state = ACS_ST_RESET;
			end
		endcase
		// reset pin is not honoured during power-down
		if (!link.resetPin_n && !inReset && !inPd) begin
			next_state = ACS_ST_RSTDLY;
		// power-down pin is not honoured during reset
		end else if (!link.power_down_n && !inReset && !inPd) begin
			next_state = ACS_ST_PDDLY;
		end
	end

	// delay loaded on entry to each timed state
	always_comb begin
		case (next_state)
			ACS_ST_RSTDLY: tmrLoadVal = 32'(T_VALID_RST);
			ACS_ST_CTLWAIT: tmrLoadVal = 32'(T_CTL);
			ACS_ST_STARTUP: tmrLoadVal = 32'(T_RUN);
			ACS_ST_FAULT: tmrLoadVal = faultCycles;
			ACS_ST_PDDLY: tmrLoadVal = 32'(T_VALID_PD);
			ACS_ST_PDSTART: tmrLoadVal = 32'(T_STARTUP);
			default: tmrLoadVal = 32'h0000_0001;
		endcase
	end

	// state register and power-stage outputs
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			state <= ACS_ST_RESET;
			powerStageValid <= 1'b0;
			speakerLow <= 1'b0;
		end else if (ce) begin
			state <= next_state;
			// valid high through drop delays
			powerStageValid <= (next_state == ACS_ST_RUN) || (next_state == ACS_ST_RSTDLY)
				|| (next_state == ACS_ST_PDDLY);
			// one edge after the fault sample
			speakerLow <= (next_state == ACS_ST_FAULT);
		end
	end

	// control port read selection; unmapped indices read zero
	always_comb begin
		case (link.ctlAddr)
			`ACS_REG_STATE: readMux = DW'(state);
			`ACS_REG_VOL_CFG: readMux = volCfg;
			`ACS_REG_RAMP_STEPS: readMux = rampSteps;
			`ACS_REG_HP_CFG: readMux = hpCfg;
			`ACS_REG_FAULT_HOLD: readMux = faultHold;
			default: readMux = '0;
		endcase
	end

	// control port: acknowledge one edge after a request
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			ctlAck <= 1'b0;
			ctlRdata <= '0;
		end else if (ce) begin
			ctlAck <= ctlHit;
			if (ctlHit && !link.ctlWrite) ctlRdata <= readMux;
		end
	end

	// configuration registers, kept through the reset pin, set to their reset values by rst_n
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			volCfg <= '0;
			rampSteps <= `ACS_RAMP_STEPS_RST;
			hpCfg <= '0;
			faultHold <= `ACS_FAULT_HOLD_RST;
		end else if (ce && ctlWr) begin
			if (link.ctlAddr == `ACS_REG_VOL_CFG) volCfg <= link.ctlWdata;
			if (link.ctlAddr == `ACS_REG_RAMP_STEPS) rampSteps <= link.ctlWdata;
			if (link.ctlAddr == `ACS_REG_HP_CFG) hpCfg <= link.ctlWdata;
			if (link.ctlAddr == `ACS_REG_FAULT_HOLD) faultHold <= link.ctlWdata;
		end
	end

	assign link.ctlAck = ctlAck;
	assign link.ctlRdata = ctlRdata;

	// step size by sample-rate class; rate code 3 is treated as the fastest
	always_comb begin
		case (volCfg[`ACS_VOL_RATE_LO +: 2])
			2'b00: stepSize = `ACS_STEP_LOW;
			2'b01: stepSize = `ACS_STEP_MID;
			default: stepSize = `ACS_STEP_HIGH;
		endcase
	end

	// ramp to silence when muted, stopped or switching
	wire hpSwitch = (link.headphone_select != hpActive);
	wire frameRise = link.frameClk && !frameQ;
	wire stepTick = frameRise && ((frameCnt + 5'h01) >= stepSize);
	always_comb begin
		if (link.mute || hpSwitch || (state != ACS_ST_RUN)) begin
			volTarget = '0;
		end else begin
			volTarget = rampSteps;
		end
	end

	// frame edges pace the ramp; timing stays on clk
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			frameQ <= 1'b0;
			frameCnt <= '0;
		end else if (ce) begin
			frameQ <= link.frameClk;
			if (stepTick) begin
				frameCnt <= '0;
			end else if (frameRise) begin
				frameCnt <= frameCnt + 5'h01;
			end
		end
	end

	// one step per tick toward target
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			volumeLevel <= '0;
			hpActive <= 1'b0;
			headphone_pwm_out <= 1'b1;
		end else if (ce) begin
			if (stepTick && (volumeLevel < volTarget)) begin
				volumeLevel <= volumeLevel + 1'b1;
			end else if (stepTick && (volumeLevel > volTarget)) begin
				volumeLevel <= volumeLevel - 1'b1;
			end
			// path changes only once the ramp has reached silence
			if (hpSwitch && (volumeLevel == '0)) hpActive <= link.headphone_select;
			headphone_pwm_out <= !(hpCfg[`ACS_HP_LINE_DIS] && !hpActive);
		end
	end
endmodule

// >>> acs_defines.svh
// constants of the amplifier control sequencer: timing, register indices, fields
// assumes the 25 MHz system clock
`ifndef ACS_DEFINES_SVH
`define ACS_DEFINES_SVH

// system clock rate
`define ACS_CLK_MHZ 25
// times in their own units
`define ACS_T_VALID_RST_NS 300
`define ACS_T_VALID_PD_US 725
`define ACS_T_CTL_US 3500
`define ACS_T_RUN_MS 10
`define ACS_T_STARTUP_MS 120
`define ACS_T_PD_MIN_NS 800
`define ACS_T_HEADPHONE_SELECT_NS 350
`define ACS_T_RESET_MS 1
// audio clock generator: clk cycles per half bit clock, bit clocks per frame
`define ACS_BCLK_HALF 4
`define ACS_BCLK_PER_FRAME 64
// ramp step sizes in frame periods
`define ACS_STEP_LOW 5'h04
`define ACS_STEP_MID 5'h08
`define ACS_STEP_HIGH 5'h10
// device control-port register indices
`define ACS_REG_STATE 8'h02
`define ACS_REG_SYS 8'h05
`define ACS_REG_VOL_CFG 8'h0E
`define ACS_REG_RAMP_STEPS 8'h0F
`define ACS_REG_HP_CFG 8'h1B
`define ACS_REG_FAULT_HOLD 8'h1C
// device fields and reset values
`define ACS_SYS_START 0
`define ACS_VOL_RATE_LO 0
`define ACS_HP_LINE_DIS 4
`define ACS_RAMP_STEPS_RST 16'h0400
`define ACS_FAULT_HOLD_RST 16'h0001
// host AHB-Lite register byte offsets
`define ACS_H_CTRL 8'h00
`define ACS_H_STATUS 8'h04
`define ACS_H_MASK 8'h08
`define ACS_H_CMD 8'h0C
`define ACS_H_RDATA 8'h10
// host control bits
`define ACS_CTRL_RESET 0
`define ACS_CTRL_PD 1
`define ACS_CTRL_MUTE 2
`define ACS_CTRL_HP 3
// host command word fields
`define ACS_CMD_GO 31
`define ACS_CMD_WRITE 24
`define ACS_CMD_ADDR_LO 16
// host status event bits
`define ACS_EV_CMD 0
`define ACS_EV_RUN 1
`define ACS_EV_RESET 2
`define ACS_EV_W 3

`endif

// >>> acs_pkg.sv
// types shared by both ends of the amplifier control sequencer
// assumes nothing beyond the defines header for its users
package acs_pkg;

	// device sequencer states, one-hot
	typedef enum logic [9:0] {
		ACS_ST_RESET = 10'b00_0000_0001,
		ACS_ST_RSTDLY = 10'b00_0000_0010,
		ACS_ST_CTLWAIT = 10'b00_0000_0100,
		ACS_ST_IDLE = 10'b00_0000_1000,
		ACS_ST_STARTUP = 10'b00_0001_0000,
		ACS_ST_RUN = 10'b00_0010_0000,
		ACS_ST_FAULT = 10'b00_0100_0000,
		ACS_ST_PDDLY = 10'b00_1000_0000,
		ACS_ST_PDOWN = 10'b01_0000_0000,
		ACS_ST_PDSTART = 10'b10_0000_0000
	} acs_dev_state_t;

endpackage

// >>> acs_link_if.sv
// pins and control port between the host controller and the amplifier
// assumes both ends share clk
`timescale 1ns/10ps
interface acs_link_if #(
	parameter int AW = 8,
	parameter int DW = 16
) ();
	// control pins, driven by the host
	logic resetPin_n;
	logic power_down_n;
	logic mute;
	logic headphone_select;
	// audio clocks, driven by the host as audio source
	logic bitClk;
	logic frameClk;
	// control port: request held until acknowledge
	logic ctlValid;
	logic ctlWrite;
	logic [AW-1:0] ctlAddr;
	logic [DW-1:0] ctlWdata;
	logic ctlAck;
	logic [DW-1:0] ctlRdata;

	modport device (
		input resetPin_n, power_down_n, mute, headphone_select, bitClk, frameClk,
		input ctlValid, ctlWrite, ctlAddr, ctlWdata,
		output ctlAck, ctlRdata
	);
	modport host (
		output resetPin_n, power_down_n, mute, headphone_select, bitClk, frameClk,
		output ctlValid, ctlWrite, ctlAddr, ctlWdata,
		input ctlAck, ctlRdata
	);
endinterface

// >>> acs_timer.sv
// reloadable down counter used for every delay of both ends
// load wins over counting; zero holds while empty
`timescale 1ns/10ps
module acs_timer #(
	parameter int W = 32
) (
	// clock and control
	input wire logic clk,
	input wire logic rst_n,
	input wire logic ce,
	// reload and status
	input wire logic load,
	input wire logic [W-1:0] loadVal,
	output logic zero
);
	logic [W-1:0] count; // cycles still to run

	// count down to zero and stop there
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			count <= '0;
		end else if (ce) begin
			if (load) begin
				count <= loadVal;
			end else if (count != '0) begin
				count <= count - 1'b1;
			end
		end
	end

	assign zero = (count == '0);
endmodule

// >>> acs_host.sv
// host end: AHB-Lite slave registers, control pins, audio clocks, command port
// assumes one AHB-Lite master and the device on the link
`timescale 1ns/10ps
`include "acs_defines.svh"
module acs_host import acs_pkg::*; #(
	parameter int AW = 8,
	parameter int DW = 16,
	parameter int T_RESET = `ACS_T_RESET_MS * 1000 * `ACS_CLK_MHZ,
	parameter int T_RUN = `ACS_T_RUN_MS * 1000 * `ACS_CLK_MHZ
) (
	// clock, reset, enable
	input wire logic clk,
	input wire logic rst_n,
	input wire logic ce,
	// AHB-Lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic [31:0] hrdata,
	output logic hresp,
	// interrupt
	output logic irq,
	// link to the device
	acs_link_if.host link
);
	// minimum pin hold times, least times rounded up
	localparam int T_PD_MIN = (`ACS_T_PD_MIN_NS * `ACS_CLK_MHZ + 999) / 1000;
	localparam int T_HP_MIN = (`ACS_T_HEADPHONE_SELECT_NS * `ACS_CLK_MHZ + 999) / 1000;

	logic [31:0] ctrl; // software control levels
	logic [`ACS_EV_W-1:0] status; // sticky events, cleared by read
	logic [`ACS_EV_W-1:0] mask; // interrupt enables
	logic [31:0] cmd; // last command word
	logic [DW-1:0] rdata; // last control-port read result
	logic cmdBusy; // request standing on the link
	logic wrPend; // write data phase pending
	logic [7:0] wrAddr; // its byte offset
	logic rstZero, runZero, pdZero, hpZero;
	logic rstArmed, runArmed; // waiting for a delay to end
	logic [3:0] divCnt; // bit clock divider
	logic [5:0] bitCnt; // bit clocks in the frame half
	logic [31:0] readMux;

	// bus decode
	wire addrPhase = hsel && htrans[1] && hready;
	wire rdStatus = addrPhase && !hwrite && (haddr[7:0] == `ACS_H_STATUS);
	wire wrCtrl = wrPend && (wrAddr == `ACS_H_CTRL);
	wire wrCmd = wrPend && (wrAddr == `ACS_H_CMD) && hwdata[`ACS_CMD_GO] && !cmdBusy;
	wire rstStart = wrCtrl && hwdata[`ACS_CTRL_RESET];
	wire cmdDone = cmdBusy && link.ctlAck;
	wire startSent = cmdDone && cmd[`ACS_CMD_WRITE]
		&& (cmd[`ACS_CMD_ADDR_LO +: AW] == `ACS_REG_SYS) && cmd[`ACS_SYS_START];
	wire pdChange = ctrl[`ACS_CTRL_PD] == link.power_down_n;
	wire hpChange = ctrl[`ACS_CTRL_HP] != link.headphone_select;
	wire bitEdge = (divCnt == 4'(`ACS_BCLK_HALF - 1));
	wire bitRise = bitEdge && !link.bitClk;
	wire halfFrame = bitRise && (bitCnt == 6'(`ACS_BCLK_PER_FRAME / 2 - 1));
	wire [`ACS_EV_W-1:0] events;
	assign events[`ACS_EV_CMD] = cmdDone;
	assign events[`ACS_EV_RUN] = runArmed && runZero;
	assign events[`ACS_EV_RESET] = rstArmed && rstZero;

	// reset pulse, start-up wait and the two minimum pin holds
	acs_timer #(.W(32)) rstTimer (.clk(clk), .rst_n(rst_n), .ce(ce),
		.load(rstStart), .loadVal(32'(T_RESET)), .zero(rstZero));
	acs_timer #(.W(32)) runTimer (.clk(clk), .rst_n(rst_n), .ce(ce),
		.load(startSent), .loadVal(32'(T_RUN)), .zero(runZero));
	acs_timer #(.W(32)) pdTimer (.clk(clk), .rst_n(rst_n), .ce(ce),
		.load(pdChange && pdZero), .loadVal(32'(T_PD_MIN)), .zero(pdZero));
	acs_timer #(.W(32)) hpTimer (.clk(clk), .rst_n(rst_n), .ce(ce),
		.load(hpChange && hpZero), .loadVal(32'(T_HP_MIN)), .zero(hpZero));

	// read selection at the address phase
	always_comb begin
		case (haddr[7:0])
			`ACS_H_CTRL: readMux = ctrl;
			`ACS_H_STATUS: readMux = 32'(status);
			`ACS_H_MASK: readMux = 32'(mask);
			`ACS_H_CMD: readMux = cmd;
			`ACS_H_RDATA: readMux = {cmdBusy, 15'h0000, 16'(rdata)};
			default: readMux = 32'h0000_0000;
		endcase
	end

	// bus slave: zero wait states, always OKAY
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			wrPend <= 1'b0;
			wrAddr <= 8'h00;
			hrdata <= 32'h0000_0000;
		end else if (ce) begin
			wrPend <= addrPhase && hwrite;
			if (addrPhase) wrAddr <= haddr[7:0];
			if (addrPhase && !hwrite) hrdata <= readMux;
		end
	end
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;

	// software registers; the reset request bit does not stay set
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			ctrl <= 32'h0000_0000;
			mask <= '0;
			cmd <= 32'h0000_0000;
		end else if (ce) begin
			if (wrCtrl) ctrl <= hwdata & ~(32'h0000_0001 << `ACS_CTRL_RESET);
			if (wrPend && (wrAddr == `ACS_H_MASK)) mask <= hwdata[`ACS_EV_W-1:0];
			if (wrCmd) cmd <= hwdata;
		end
	end

	// events and command flow; a new event beats the read that clears
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			status <= '0;
			cmdBusy <= 1'b0;
			rdata <= '0;
			rstArmed <= 1'b0;
			runArmed <= 1'b0;
			irq <= 1'b0;
		end else if (ce) begin
			status <= (rdStatus ? '0 : status) | events;
			irq <= |(((rdStatus ? '0 : status) | events) & mask);
			if (wrCmd) cmdBusy <= 1'b1;
			else if (cmdDone) cmdBusy <= 1'b0;
			if (cmdDone && !cmd[`ACS_CMD_WRITE]) rdata <= link.ctlRdata;
			if (rstStart) rstArmed <= 1'b1;
			else if (rstZero) rstArmed <= 1'b0;
			// device is not running before this wait ends
			if (startSent) runArmed <= 1'b1;
			else if (runZero) runArmed <= 1'b0;
		end
	end

	// control pins; a power-down or headphone select change waits out the previous hold
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			link.resetPin_n <= 1'b0;
			link.power_down_n <= 1'b1;
			link.mute <= 1'b0;
			link.headphone_select <= 1'b0;
		end else if (ce) begin
			link.resetPin_n <= rstZero && !rstStart;
			if (pdChange && pdZero) link.power_down_n <= !ctrl[`ACS_CTRL_PD];
			if (hpChange && hpZero) link.headphone_select <= ctrl[`ACS_CTRL_HP];
			link.mute <= ctrl[`ACS_CTRL_MUTE];
		end
	end

	// audio clocks: 64 bit clocks per frame
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			divCnt <= 4'h0;
			bitCnt <= 6'h00;
			link.bitClk <= 1'b0;
			link.frameClk <= 1'b0;
		end else if (ce) begin
			divCnt <= bitEdge ? 4'h0 : divCnt + 4'h1;
			if (bitEdge) link.bitClk <= !link.bitClk;
			if (halfFrame) begin
				bitCnt <= 6'h00;
				link.frameClk <= !link.frameClk;
			end else if (bitRise) begin
				bitCnt <= bitCnt + 6'h01;
			end
		end
	end

	// control-port request stands until acknowledged
	assign link.ctlValid = cmdBusy;
	assign link.ctlWrite = cmd[`ACS_CMD_WRITE];
	assign link.ctlAddr = cmd[`ACS_CMD_ADDR_LO +: AW];
	assign link.ctlWdata = cmd[DW-1:0];
endmodule

// >>> acs_link_asserts.sv
// link checker: audio clocks, reset pulse, control handshake, pin spacing
// assumes one clock and synchronous active-low rst_n
`timescale 1ns/10ps
module acs_link_asserts #(
	parameter int T_RESET = 50,
	parameter int T_CTL = 100
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// link signals
	input wire logic resetPin_n,
	input wire logic power_down_n,
	input wire logic headphone_select,
	input wire logic bitClk,
	input wire logic frameClk,
	input wire logic ctlValid,
	input wire logic ctlWrite,
	input wire logic [7:0] ctlAddr,
	input wire logic [15:0] ctlWdata,
	input wire logic ctlAck
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	logic bitPrev; // audio clock history
	logic framePrev;
	int bitCnt; // bit clocks in the running frame
	int lowCnt; // cycles the reset pin has been low
	int openCnt; // cycles since the reset pin went high
	int pdAge; // cycles since each pin last moved
	int hpAge;
	wire logic bitRise = bitClk & ~bitPrev;
	wire logic frameRise = frameClk & ~framePrev;
	// helper counters; the power-on release must not look like a short pulse
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			bitPrev <= 1'b0;
			framePrev <= 1'b0;
			bitCnt <= 0;
			lowCnt <= T_RESET;
			openCnt <= 0;
			pdAge <= 1000;
			hpAge <= 1000;
		end else begin
			bitPrev <= bitClk;
			framePrev <= frameClk;
			bitCnt <= frameRise ? 0 : bitCnt + int'(bitRise);
			lowCnt <= resetPin_n ? 0 : lowCnt + 1;
			openCnt <= resetPin_n ? openCnt + 1 : 0;
			pdAge <= $changed(power_down_n) ? 1 : pdAge + 1;
			hpAge <= $changed(headphone_select) ? 1 : hpAge + 1;
		end
	end
	property p_frame_bits; frameRise |-> (bitCnt + int'(bitRise)) inside {[32:64]}; endproperty
	a_frame_bits: assert property (p_frame_bits)
		else $error("bit clocks per frame out of range");
	property p_reset_width; $rose(resetPin_n) |-> lowCnt >= T_RESET - 1; endproperty
	a_reset_width: assert property (p_reset_width)
		else $error("reset pulse too short");
	property p_port_closed; ctlAck |-> openCnt >= T_CTL; endproperty
	a_port_closed: assert property (p_port_closed)
		else $error("control port answered too early");
	property p_ack_pulse; ctlAck |=> !ctlAck; endproperty
	a_ack_pulse: assert property (p_ack_pulse)
		else $error("acknowledge longer than one cycle");
	property p_ack_cause; ctlAck |-> ctlValid && $past(ctlValid); endproperty
	a_ack_cause: assert property (p_ack_cause)
		else $error("acknowledge without request");
	property p_req_drop; ctlAck |=> !ctlValid; endproperty
	a_req_drop: assert property (p_req_drop)
		else $error("request kept after acknowledge");
	// a waiting request must not move
	property p_req_hold; ctlValid && !ctlAck |=>
		ctlValid && $stable(ctlAddr) && $stable(ctlWrite) && $stable(ctlWdata); endproperty
	a_req_hold: assert property (p_req_hold)
		else $error("request changed before acknowledge");
	property p_pd_width; $changed(power_down_n) |-> pdAge >= 20; endproperty
	a_pd_width: assert property (p_pd_width)
		else $error("power-down level too short");
	property p_hp_width; $changed(headphone_select) |-> hpAge >= 9; endproperty
	a_hp_width: assert property (p_hp_width)
		else $error("headphone select level too short");
	c_write: cover property (ctlAck && ctlWrite);
	c_reset: cover property ($rose(resetPin_n));
	c_pdown: cover property ($fell(power_down_n));
	c_headphone_select: cover property ($rose(headphone_select));
endmodule

// >>> amp_control_sequencer_tb.sv
// bench: AHB-Lite master on the host end, fault input on the device end
// assumes shortened delays; one audio frame lasts 512 clk cycles
`timescale 1ns/10ps
`include "acs_defines.svh"
module amp_control_sequencer_tb import acs_pkg::*;;
	logic clk; // clock, reset and bus
	logic rst_n;
	logic ce;
	logic [2:0] hsize;
	logic hsel;
	logic hwrite;
	logic [1:0] htrans;
	logic [31:0] haddr;
	logic [31:0] hwdata;
	logic hreadyout;
	logic [31:0] hrdata;
	logic irq;
	logic backend_fault_n; // power stage side
	logic powerStageValid;
	logic speakerLow;
	logic headphone_pwm_out;
	logic hpActive;
	logic [15:0] volumeLevel;
	logic [15:0] volTarget; // bench state
	logic [3:0] ctrl;
	logic [31:0] rd;
	int mismatches;
	int tests_run;
	int cyc;
	int steps;
	acs_link_if acs_link_if_inst ();
	acs_host #(.T_RESET(50), .T_RUN(200)) acs_host_inst (.clk, .rst_n, .ce, .hsel, .haddr,
		.htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout), .hreadyout, .hrdata, .hresp(),
		.irq, .link(acs_link_if_inst));
	acs_device #(.T_VALID_PD(50), .T_CTL(100), .CYC_PER_MS(20)) acs_device_inst (.clk, .rst_n,
		.ce, .link(acs_link_if_inst), .backend_fault_n, .powerStageValid, .speakerLow,
		.headphone_pwm_out, .hpActive, .volumeLevel);
	acs_link_asserts acs_link_asserts_inst (.clk, .rst_n,
		.resetPin_n(acs_link_if_inst.resetPin_n),
		.power_down_n(acs_link_if_inst.power_down_n), .bitClk(acs_link_if_inst.bitClk),
		.headphone_select(acs_link_if_inst.headphone_select),
		.frameClk(acs_link_if_inst.frameClk), .ctlValid(acs_link_if_inst.ctlValid),
		.ctlWrite(acs_link_if_inst.ctlWrite), .ctlAddr(acs_link_if_inst.ctlAddr),
		.ctlWdata(acs_link_if_inst.ctlWdata), .ctlAck(acs_link_if_inst.ctlAck));
	// free-running system clock
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			mismatches++;
			$display("mismatch %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", tests_run, mismatches);
		if (mismatches == 0 && tests_run > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	task automatic timeout(input string nm);
		mismatches++;
		$display("mismatch %s expected done seen timeout", nm);
		print_verdict();
	endtask
	function automatic logic probe(input int w);
		case (w)
			0: return irq;
			1: return powerStageValid;
			2: return speakerLow;
			3: return hpActive;
			4: return headphone_pwm_out;
			default: return volumeLevel === volTarget;
		endcase
	endfunction
	// sample 1 ns after the edge
	task automatic wait_for(input int w, input logic v, input int lim);
		cyc = 0;
		do begin
			@(posedge clk);
			#1;
			cyc++;
			if (cyc > lim) timeout("wait");
		end while (probe(w) !== v);
	endtask
	task automatic rdy();
		int n;
		n = 0;
		do begin
			@(posedge clk);
			n++;
			if (n > 50) timeout("hready");
		end while (hreadyout !== 1'b1);
	endtask
	// one AHB-Lite single word transfer; read data lands in rd
	task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
		hsel <= 1'b1;
		htrans <= 2'b10;
		haddr <= {24'h00_0000, a};
		hwrite <= wr;
		hsize <= 3'h2;
		rdy();
		htrans <= 2'b00;
		hwdata <= wd;
		rdy();
		rd = hrdata;
	endtask
	task automatic ev(input int b, input int lo, input int hi);
		wait_for(0, 1'b1, hi);
		ahb(1'b0, `ACS_H_STATUS, 32'h0000_0000);
		check("status event", rd[b], 1'b1);
		check("event delay", cyc >= lo, 1'b1);
	endtask
	task automatic cmd(input logic wr, input logic [7:0] idx, input logic [15:0] d);
		ahb(1'b1, `ACS_H_CMD, {1'b1, 6'h00, wr, idx, d});
		ev(`ACS_EV_CMD, 0, 2000);
	endtask
	task automatic ctl(input logic [3:0] v);
		ahb(1'b1, `ACS_H_CTRL, {28'h000_0000, v});
	endtask
	function automatic int ramp_cyc(input int r);
		int sz;
		sz = (r == 0) ? 4 : (r == 1) ? 8 : 16;
		return steps * sz * 2 * `ACS_BCLK_HALF * `ACS_BCLK_PER_FRAME;
	endfunction
	initial begin
		void'($urandom(32'h0000_7643));
		ce = 1'b1;
		hsize = 3'h0;
		mismatches = 0;
		tests_run = 0;
		rst_n = 1'b0;
		hsel = 1'b0;
		htrans = 2'b00;
		haddr = 32'h0000_0000;
		hwrite = 1'b0;
		hwdata = 32'h0000_0000;
		backend_fault_n = 1'b1;
		ctrl = 4'h0;
		volTarget = 16'h0000;
		repeat (10) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		ahb(1'b0, `ACS_H_RDATA, 32'h0000_0000);
		check("rdata reset", rd, 32'h0000_0000);
		ahb(1'b0, 8'h14, 32'h0000_0000);
		check("unmapped", rd, 32'h0000_0000);
		// masked reset event stays sticky
		ctl(4'h1);
		repeat (100) @(posedge clk);
		#1;
		check("irq masked", irq, 1'b0);
		ahb(1'b1, `ACS_H_MASK, 32'h0000_0007);
		ev(`ACS_EV_RESET, 0, 10);
		$display("test reset done");
		steps = 2 + ($urandom % 2);
		cmd(1'b1, `ACS_REG_RAMP_STEPS, steps[15:0]);
		cmd(1'b1, `ACS_REG_SYS, 16'h0001);
		ev(`ACS_EV_RUN, 150, 400);
		cmd(1'b0, `ACS_REG_STATE, 16'h0000);
		ahb(1'b0, `ACS_H_RDATA, 32'h0000_0000);
		check("state", rd[9:0], ACS_ST_RUN);
		$display("test start done");
		volTarget = steps[15:0];
		wait_for(5, 1'b1, 8000);
		// each rate once: rates 0 and 2 ramp down, rate 1 up
		for (int r = 0; r < 3; r++) begin
			cmd(1'b1, `ACS_REG_VOL_CFG, r[15:0]);
			ctrl[`ACS_CTRL_MUTE] = ~ctrl[`ACS_CTRL_MUTE];
			ctl(ctrl);
			volTarget = ctrl[`ACS_CTRL_MUTE] ? 16'h0000 : steps[15:0];
			wait_for(5, 1'b1, 30000);
			check("ramp", cyc * steps > ramp_cyc(r) * (steps - 1), 1'b1);
			check("ramp", cyc <= ramp_cyc(r) + 64, 1'b1);
		end
		$display("test ramp done");
		cmd(1'b1, `ACS_REG_FAULT_HOLD, 16'h0001);
		backend_fault_n <= 1'b0;
		@(posedge clk);
		#1;
		check("speaker low", speakerLow, 1'b1);
		check("valid fault", powerStageValid, 1'b0);
		repeat (60) @(posedge clk);
		#1;
		check("fault hold", speakerLow, 1'b1);
		backend_fault_n <= 1'b1;
		wait_for(2, 1'b0, 40);
		wait_for(1, 1'b1, 4);
		$display("test fault done");
		check("hp line on", headphone_pwm_out, 1'b1);
		cmd(1'b1, `ACS_REG_HP_CFG, 16'h0010);
		wait_for(4, 1'b0, 4);
		ctrl[`ACS_CTRL_HP] = 1'b1;
		ctl(ctrl);
		wait_for(3, 1'b1, 30000);
		wait_for(4, 1'b1, 4);
		$display("test headphone done");
		ctrl[`ACS_CTRL_PD] = 1'b1;
		ctl(ctrl);
		wait_for(1, 1'b0, 200);
		check("pd valid", cyc >= 45 && cyc <= 60, 1'b1);
		ctl(ctrl | 4'h1);
		ev(`ACS_EV_RESET, 45, 200);
		ctrl[`ACS_CTRL_PD] = 1'b0;
		ctl(ctrl);
		// freeze mid start-up: the delay must not advance
		repeat (3) @(posedge clk);
		ce <= 1'b0;
		repeat (40) @(posedge clk);
		ce <= 1'b1;
		wait_for(1, 1'b1, 3000);
		check("startup", cyc >= 2390, 1'b1);
		ctl(ctrl | 4'h1);
		wait_for(1, 1'b0, 30);
		check("reset valid", cyc >= 6 && cyc <= 12, 1'b1);
		$display("test power done");
		print_verdict();
	end
endmodule
